/* verilog/tsq_regs.sv */
// trigger step queue register bank with axi4-lite slave and step port
//
// Notes on behaviour
// - 16-bit literal register, read/write, resets zero
// - pointer bits 4..0 name active step
// - pointer bits 15..5 read zero, ignore writes
// - pointer writes ignored while sequencer busy
// - sixteen 16-bit queue registers, reset zero
// - high byte holds odd step 2n+1
// - low byte holds even step 2n
// - queue writes ignored while sequencer busy
// - step byte: command high nibble, option low
// - add-adjust option five adds adjust into literal
// - jump loads command bit0 and option into pointer
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module tsq_regs
   import tsq_pkg::*;
#(
   parameter int QUEUE_REGS = 16
)
(
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [TSQ_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [TSQ_DATA_W-1:0] s_axi_wdata,
   input wire logic [TSQ_STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [TSQ_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [TSQ_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // sequencer side
   input wire logic seq_busy,
   input wire logic step_exec,
   input wire logic [TSQ_REG_W-1:0] adjust_value,
   output logic [TSQ_REG_W-1:0] literal_value,
   output logic [TSQ_PTR_W-1:0] active_step_pointer,
   output logic [TSQ_BYTE_W-1:0] active_step_byte,
   output logic [3:0] step_cmd,
   output logic [3:0] step_option,
   output logic step_byte_valid
);
   localparam int QIDX_W = $clog2(QUEUE_REGS);
   localparam int SLOTS = 2 * QUEUE_REGS;

   // only power-of-two depths up to what the 5-bit pointer reaches
   initial
   begin
      if (QUEUE_REGS < 2 || QUEUE_REGS > (1 << TSQ_QIDX_MAX_W) ||
          (QUEUE_REGS & (QUEUE_REGS - 1)) != 0)
      begin
         $error("tsq_regs: QUEUE_REGS must be a power of two from 2 to 16");
      end
   end

   // address decode shared by the read and write paths
   function automatic tsq_sel_e decode(input logic [TSQ_ADDR_W-1:0] a);
      logic [TSQ_ADDR_W-1:0] w;
      w = {a[TSQ_ADDR_W-1:TSQ_WORD_LSB], {TSQ_WORD_LSB{1'b0}}};
      if (w == TSQ_OFF_LITERAL)
         decode = TSQ_SEL_LITERAL;
      else if (w == TSQ_OFF_POINTER)
         decode = TSQ_SEL_POINTER;
      else if (w == TSQ_OFF_STATUS)
         decode = TSQ_SEL_STATUS;
      else if (a[TSQ_QWIN_HI:TSQ_QWIN_LO] == TSQ_OFF_QUEUE[TSQ_QWIN_HI:TSQ_QWIN_LO] &&
               32'(a[TSQ_QWIN_LO-1:TSQ_WORD_LSB]) < QUEUE_REGS)
         decode = TSQ_SEL_QUEUE;
      else
         decode = TSQ_SEL_NONE;
   endfunction

   // queue word index from a byte address
   function automatic logic [QIDX_W-1:0] qindex(input logic [TSQ_ADDR_W-1:0] a);
      qindex = a[TSQ_WORD_LSB +: QIDX_W];
   endfunction

   // byte-lane merge of a 16-bit register with bus write data
   function automatic logic [TSQ_REG_W-1:0] merge16(input logic [TSQ_REG_W-1:0] old,
                                                    input logic [TSQ_REG_W-1:0] nw,
                                                    input logic [1:0] be);
      merge16 = old;
      if (be[0])
         merge16[TSQ_BYTE_W-1:0] = nw[TSQ_BYTE_W-1:0];
      if (be[1])
         merge16[TSQ_REG_W-1:TSQ_BYTE_W] = nw[TSQ_REG_W-1:TSQ_BYTE_W];
   endfunction

   // next slot with wrap at the queue's end
   function automatic logic [TSQ_PTR_W-1:0] next_slot(input logic [TSQ_PTR_W-1:0] p);
      logic [TSQ_PTR_W-1:0] mask;
      mask = TSQ_PTR_W'(SLOTS - 1);
      next_slot = (p + 1'b1) & mask;
   endfunction

   // software-visible state
   logic [TSQ_REG_W-1:0] literal_q, literal_d; // literal value
   logic [TSQ_PTR_W-1:0] ptr_q, ptr_d; // active step pointer
   // write channel holding registers
   logic aw_have_q, w_have_q; // address / data captured
   logic [TSQ_ADDR_W-1:0] wr_addr_q;
   logic [TSQ_REG_W-1:0] wr_data_q; // only the low half is ever stored
   logic [1:0] wr_be_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   // read channel
   tsq_rd_e rd_state_q, rd_state_d;
   logic [TSQ_ADDR_W-1:0] rd_addr_q;
   logic [TSQ_DATA_W-1:0] rdata_q;
   logic [1:0] rresp_q;
   // step byte pipeline
   logic [TSQ_PTR_W-1:0] ptr_s1_q, ptr_s2_q; // pointer matching each stage
   logic [TSQ_BYTE_W-1:0] byte_q;
   logic [TSQ_REG_W-1:0] bus_word, step_word;

   // handshakes, each from registered state only
   wire aw_fire = s_axi_awvalid && s_axi_awready;
   wire w_fire = s_axi_wvalid && s_axi_wready;
   wire ar_fire = s_axi_arvalid && s_axi_arready;
   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready = !w_have_q && !bvalid_q;
   assign s_axi_arready = (rd_state_q == TSQ_RD_IDLE);

   // write performed once both halves are held
   wire wr_go = aw_have_q && w_have_q;
   wire tsq_sel_e wr_sel = decode(wr_addr_q);
   wire tsq_sel_e rd_sel = decode(rd_addr_q);
   wire wr_locked = seq_busy;
   wire wr_lit = wr_go && wr_sel == TSQ_SEL_LITERAL && !wr_locked;
   wire wr_ptr = wr_go && wr_sel == TSQ_SEL_POINTER && !wr_locked;
   wire wr_que = wr_go && wr_sel == TSQ_SEL_QUEUE && !wr_locked;

   wire [3:0] cur_cmd = byte_q[TSQ_CMD_HI:TSQ_CMD_LO];
   wire [3:0] cur_opt = byte_q[TSQ_OPT_HI:TSQ_OPT_LO];
   // a step only acts on a byte that matches the current pointer
   wire exec_ok = step_exec && seq_busy && step_byte_valid;
   wire do_add = exec_ok && cur_cmd == TSQ_CMD_ADD && cur_opt == TSQ_OPT_ADD_LITERAL;
   wire do_jump = exec_ok && cur_cmd[3:1] == TSQ_CMD_JUMP_TOP;
   wire [TSQ_PTR_W-1:0] jump_target = TSQ_PTR_W'({cur_cmd[0], cur_opt}) &
                                      TSQ_PTR_W'(SLOTS - 1);

   // literal next value; software and the add never meet since writes lock when busy
   always_comb
   begin
      literal_d = literal_q;
      if (wr_lit)
         literal_d = merge16(literal_q, wr_data_q, wr_be_q);
      else if (do_add)
         literal_d = literal_q + adjust_value;
   end

   // pointer next value
   always_comb
   begin
      ptr_d = ptr_q;
      // only low five bits take the write
      if (wr_ptr && wr_be_q[0])
         ptr_d = wr_data_q[TSQ_PTR_W-1:0] & TSQ_PTR_W'(SLOTS - 1);
      else if (do_jump)
         ptr_d = jump_target;
      else if (exec_ok)
         ptr_d = next_slot(ptr_q);
   end

   // read state sequence
   always_comb
   begin
      case (rd_state_q)
         TSQ_RD_IDLE: rd_state_d = ar_fire ? TSQ_RD_FETCH : TSQ_RD_IDLE;
         TSQ_RD_FETCH: rd_state_d = TSQ_RD_RESP;
         TSQ_RD_RESP: rd_state_d = s_axi_rready ? TSQ_RD_IDLE : TSQ_RD_RESP;
         default: rd_state_d = TSQ_RD_IDLE;
      endcase
   end

   // queue words: even step low byte, odd step high byte
   tsq_queue_mem #(
      .DEPTH(QUEUE_REGS),
      .AW(QIDX_W)
   ) u_mem (
      .aclk(aclk),
      .aresetn(aresetn),
      .we(wr_que),
      .wbe(wr_be_q),
      .waddr(qindex(wr_addr_q)),
      .wdata(wr_data_q),
      .bus_raddr(qindex(s_axi_araddr)),
      .bus_rdata_q(bus_word),
      .step_raddr(QIDX_W'(ptr_q[TSQ_PTR_W-1:1])),
      .step_rdata_q(step_word)
   );

   // read data mux, captured into rdata_q in the fetch state
   logic [TSQ_DATA_W-1:0] rd_mux;
   always_comb
   begin
      rd_mux = '0;
      case (rd_sel)
         TSQ_SEL_LITERAL: rd_mux = TSQ_DATA_W'(literal_q);
         TSQ_SEL_POINTER: rd_mux = TSQ_DATA_W'(ptr_q);
         TSQ_SEL_STATUS: rd_mux[TSQ_STAT_BUSY_BIT] = seq_busy;
         TSQ_SEL_QUEUE: rd_mux = TSQ_DATA_W'(bus_word);
         default: rd_mux = '0;
      endcase
   end

   // write channel: capture each half, answer once both are done
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         wr_addr_q <= '0;
         wr_data_q <= '0;
         wr_be_q <= '0;
         bvalid_q <= 1'b0;
         bresp_q <= TSQ_RESP_OKAY;
      end
      else
      begin
         if (aw_fire)
         begin
            aw_have_q <= 1'b1;
            wr_addr_q <= s_axi_awaddr;
         end
         if (w_fire)
         begin
            w_have_q <= 1'b1;
            wr_data_q <= s_axi_wdata[TSQ_REG_W-1:0];
            wr_be_q <= s_axi_wstrb[1:0];
         end
         if (wr_go)
         begin
            // locked writes to mapped registers still answer okay, they just change nothing
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= (wr_sel == TSQ_SEL_NONE) ? TSQ_RESP_DECERR : TSQ_RESP_OKAY;
         end
         else if (bvalid_q && s_axi_bready)
         begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // read channel registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_state_q <= TSQ_RD_IDLE;
         rd_addr_q <= '0;
         rdata_q <= '0;
         rresp_q <= TSQ_RESP_OKAY;
      end
      else
      begin
         rd_state_q <= rd_state_d;
         if (ar_fire)
            rd_addr_q <= s_axi_araddr;
         // queue word is ready from the memory flop in this state
         if (rd_state_q == TSQ_RD_FETCH)
         begin
            rdata_q <= rd_mux;
            rresp_q <= (rd_sel == TSQ_SEL_NONE) ? TSQ_RESP_DECERR : TSQ_RESP_OKAY;
         end
      end
   end

   // literal and pointer registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         literal_q <= TSQ_LITERAL_RST;
         ptr_q <= TSQ_PTR_RST;
      end
      else
      begin
         literal_q <= literal_d;
         ptr_q <= ptr_d;
      end
   end

   // step byte pipeline: word fetch, then pick even or odd half
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ptr_s1_q <= TSQ_PTR_RST;
         ptr_s2_q <= TSQ_PTR_RST;
         byte_q <= TSQ_BYTE_RST;
      end
      else
      begin
         ptr_s1_q <= ptr_q;
         ptr_s2_q <= ptr_s1_q;
         // odd slot high byte, even slot low byte
         byte_q <= ptr_s1_q[0] ? step_word[TSQ_REG_W-1:TSQ_BYTE_W]
                               : step_word[TSQ_BYTE_W-1:0];
      end
   end

   // byte is trustworthy only once both stages saw the same pointer
   assign step_byte_valid = (ptr_s2_q == ptr_q) && (ptr_s1_q == ptr_q);
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = (rd_state_q == TSQ_RD_RESP);
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign literal_value = literal_q;
   assign active_step_pointer = ptr_q;
   assign active_step_byte = byte_q;
   assign step_cmd = cur_cmd;
   assign step_option = cur_opt;
endmodule
`default_nettype wire

/* verilog/tsq_pkg.sv */
// shared constants and types for the trigger step queue register bank
package tsq_pkg;
   // bus geometry
   localparam int TSQ_DATA_W = 32;
   localparam int TSQ_ADDR_W = 8;
   localparam int TSQ_STRB_W = TSQ_DATA_W / 8;
   // register byte offsets
   localparam logic [7:0] TSQ_OFF_LITERAL = 8'h00;
   localparam logic [7:0] TSQ_OFF_POINTER = 8'h04;
   localparam logic [7:0] TSQ_OFF_STATUS = 8'h08;
   localparam logic [7:0] TSQ_OFF_QUEUE = 8'h40;
   // queue window: top address bits select it, word index follows
   localparam int TSQ_QWIN_HI = 7;
   localparam int TSQ_QWIN_LO = 6;
   localparam int TSQ_WORD_LSB = 2;
   localparam int TSQ_QIDX_MAX_W = 4;
   // register widths and reset values
   localparam int TSQ_REG_W = 16;
   localparam int TSQ_PTR_W = 5;
   localparam int TSQ_BYTE_W = 8;
   localparam logic [15:0] TSQ_LITERAL_RST = 16'h0000;
   localparam logic [4:0] TSQ_PTR_RST = 5'h00;
   localparam logic [15:0] TSQ_QUEUE_RST = 16'h0000;
   localparam logic [7:0] TSQ_BYTE_RST = 8'h00;
   // status register bit
   localparam int TSQ_STAT_BUSY_BIT = 0;
   // step byte fields
   localparam int TSQ_CMD_HI = 7;
   localparam int TSQ_CMD_LO = 4;
   localparam int TSQ_OPT_HI = 3;
   localparam int TSQ_OPT_LO = 0;
   localparam logic [3:0] TSQ_CMD_ADD = 4'h1;
   localparam logic [3:0] TSQ_OPT_ADD_LITERAL = 4'h5;
   localparam logic [2:0] TSQ_CMD_JUMP_TOP = 3'h5;
   // axi responses
   localparam logic [1:0] TSQ_RESP_OKAY = 2'h0;
   localparam logic [1:0] TSQ_RESP_DECERR = 2'h3;
   // register select after address decode
   typedef enum logic [2:0] {
      TSQ_SEL_NONE = 3'h0,
      TSQ_SEL_LITERAL = 3'h1,
      TSQ_SEL_POINTER = 3'h2,
      TSQ_SEL_STATUS = 3'h3,
      TSQ_SEL_QUEUE = 3'h4
   } tsq_sel_e;
   // read channel states, one bit changes per step except resp back to idle
   typedef enum logic [1:0] {
      TSQ_RD_IDLE = 2'h0,
      TSQ_RD_FETCH = 2'h1,
      TSQ_RD_RESP = 2'h3
   } tsq_rd_e;
endpackage

/* verilog/tsq_queue_mem.sv */
// step queue storage: byte-writable words, two registered read ports
`timescale 1ns/1ns
`default_nettype none
module tsq_queue_mem
   import tsq_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int AW = 4
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic we,
   input wire logic [1:0] wbe,
   input wire logic [AW-1:0] waddr,
   input wire logic [TSQ_REG_W-1:0] wdata,
   input wire logic [AW-1:0] bus_raddr,
   output logic [TSQ_REG_W-1:0] bus_rdata_q,
   input wire logic [AW-1:0] step_raddr,
   output logic [TSQ_REG_W-1:0] step_rdata_q
);
   // storage words, cleared by reset like every other register
   logic [TSQ_REG_W-1:0] mem_q [DEPTH];

   initial
   begin
      if (DEPTH < 1 || DEPTH > (1 << AW))
      begin
         $error("tsq_queue_mem: depth does not fit address width");
      end
   end

   // write with byte lanes, reads registered on both ports
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem_q[i] <= TSQ_QUEUE_RST;
         end
         bus_rdata_q <= TSQ_QUEUE_RST;
         step_rdata_q <= TSQ_QUEUE_RST;
      end
      else
      begin
         for (int b = 0; b < 2; b++)
         begin
            if (we && wbe[b])
            begin
               mem_q[waddr][b*TSQ_BYTE_W +: TSQ_BYTE_W] <= wdata[b*TSQ_BYTE_W +: TSQ_BYTE_W];
            end
         end
         bus_rdata_q <= mem_q[bus_raddr];
         step_rdata_q <= mem_q[step_raddr];
      end
   end
endmodule
`default_nettype wire

/* testbench/tsq_regs_props.sv */
// concurrent checks on the trigger step queue register bank ports
`timescale 1ns/1ns
`default_nettype none
module tsq_regs_props
   import tsq_pkg::*;
#(
   parameter int QUEUE_REGS = 16
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [TSQ_DATA_W-1:0] s_axi_rdata,
   input wire logic seq_busy,
   input wire logic step_exec,
   input wire logic [TSQ_REG_W-1:0] adjust_value,
   input wire logic [TSQ_REG_W-1:0] literal_value,
   input wire logic [TSQ_PTR_W-1:0] active_step_pointer,
   input wire logic [TSQ_BYTE_W-1:0] active_step_byte,
   input wire logic [3:0] step_cmd,
   input wire logic [3:0] step_option,
   input wire logic step_byte_valid
);
   // highest legal slot index for this queue depth
   localparam logic [4:0] PMAX = 5'(2 * QUEUE_REGS - 1);
   // a step that the bank really acts on
   wire logic acc = step_exec && seq_busy && step_byte_valid;
   // jump family: top three command bits 101
   wire logic jmp = step_cmd[3:1] == TSQ_CMD_JUMP_TOP;
   wire logic add = step_cmd == TSQ_CMD_ADD && step_option == TSQ_OPT_ADD_LITERAL;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   AST_PTR_LOCK: assert property (seq_busy && !acc |=> $stable(active_step_pointer))
      else $error("pointer moved while locked");
   AST_LIT_LOCK: assert property (seq_busy && !acc |=> $stable(literal_value))
      else $error("literal moved while locked");
   AST_ADD: assert property (acc && add |=>
      literal_value == $past(literal_value) + $past(adjust_value))
      else $error("add-adjust sum wrong");
   AST_JUMP: assert property (acc && jmp |=>
      active_step_pointer == ({$past(step_cmd[0]), $past(step_option)} & PMAX))
      else $error("jump target wrong");
   AST_ADV: assert property (acc && !jmp |=>
      active_step_pointer == (($past(active_step_pointer) + 5'h01) & PMAX))
      else $error("pointer advance wrong");
   AST_FIELDS: assert property (step_cmd == active_step_byte[7:4] && step_option == active_step_byte[3:0])
      else $error("step fields split wrong");
   AST_PTR_RANGE: assert property (active_step_pointer <= PMAX)
      else $error("pointer out of range");
   AST_BYTE_HOLD: assert property (seq_busy && !acc && step_byte_valid |=>
      step_byte_valid && $stable(active_step_byte))
      else $error("step byte changed while locked");
   AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
      else $error("read answer not two cycles after address");
   AST_RD_HI: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   // main scenarios reached
   cover property (acc && jmp);
   cover property (acc && add);
   cover property (acc && active_step_pointer == PMAX);
endmodule
bind tsq_regs tsq_regs_props #(.QUEUE_REGS(QUEUE_REGS)) i_props (.aclk(aclk), .aresetn(aresetn),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rdata(s_axi_rdata), .seq_busy(seq_busy), .step_exec(step_exec),
   .adjust_value(adjust_value), .literal_value(literal_value),
   .active_step_pointer(active_step_pointer), .active_step_byte(active_step_byte),
   .step_cmd(step_cmd), .step_option(step_option), .step_byte_valid(step_byte_valid));
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the trigger step queue register bank
`timescale 1ns/1ns
`default_nettype none
module tb;
   import tsq_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr, active_step_byte;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, step_cmd, step_option;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic seq_busy, step_exec, step_byte_valid;
   logic [15:0] adjust_value, literal_value;
   logic [4:0] active_step_pointer;
   int fail_count, comparisons;
   tsq_regs #(.QUEUE_REGS(16)) i_dut (.*);
   task automatic test_done();
      if (fail_count == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // value compare, four-state exact
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // a wait that ran out ends the run as a mismatch
   task automatic hang(input string nm);
      chk(nm, 32'h0000_0001, 32'h0000_0000);
      test_done();
   endtask
   // axi write; readies looked at mid-cycle, where they hold until the edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be,
                     input logic [1:0] er);
      logic aw, w, b;
      logic [1:0] r;
      int n;
      n = 0;
      b = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      // upper data and strobes set on purpose: they must be ignored
      s_axi_wdata <= {16'hFFFF, d};
      s_axi_wstrb <= {2'b11, be};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!b)
      begin
         @(negedge aclk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid && s_axi_bready;
         r = s_axi_bresp;
         @(posedge aclk);
         if (aw)
            s_axi_awvalid <= 1'b0;
         if (w)
            s_axi_wvalid <= 1'b0;
         if (b)
            s_axi_bready <= 1'b0;
         n++;
         if (n > 50)
            hang("write answer");
      end
      chk("bresp", {30'h0, er}, {30'h0, r});
   endtask
   // axi read with data and response compared
   task automatic rd(input logic [7:0] a, input logic [15:0] ex, input logic [1:0] er);
      logic ar, rv;
      logic [31:0] dt;
      logic [1:0] r;
      int n;
      n = 0;
      rv = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!rv)
      begin
         @(negedge aclk);
         ar = s_axi_arvalid && s_axi_arready;
         rv = s_axi_rvalid && s_axi_rready;
         dt = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ar)
            s_axi_arvalid <= 1'b0;
         if (rv)
            s_axi_rready <= 1'b0;
         n++;
         if (n > 50)
            hang("read answer");
      end
      chk("rdata", {16'h0000, ex}, dt);
      chk("rresp", {30'h0, er}, {30'h0, r});
   endtask
   // the step byte is refetched after each pointer change
   task automatic wait_valid();
      int n;
      n = 0;
      do
      begin
         @(negedge aclk);
         n++;
         if (n > 20)
            hang("step byte valid");
      end
      while (step_byte_valid !== 1'b1);
   endtask
   // one executed step, then the new pointer
   task automatic exec_step(input logic [4:0] ep);
      wait_valid();
      @(posedge aclk);
      step_exec <= 1'b1;
      @(posedge aclk);
      step_exec <= 1'b0;
      @(negedge aclk);
      chk("pointer", {27'h0, ep}, {27'h0, active_step_pointer});
   endtask
   initial
   begin
      aclk = 1'b0;
      forever
         #5 aclk = ~aclk;
   end
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = '0;
      {seq_busy, step_exec} = 2'b00;
      // adjust near the top so the add wraps modulo 2^16
      adjust_value = 16'hFFF0;
      fail_count = 0;
      comparisons = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(TSQ_OFF_LITERAL, 16'h0000, TSQ_RESP_OKAY);
      rd(TSQ_OFF_POINTER, 16'h0000, TSQ_RESP_OKAY);
      // each slot p gets byte 80h+p, so a swapped half shows at once
      for (int n = 0; n < 16; n++)
      begin
         rd(TSQ_OFF_QUEUE + 8'(4 * n), 16'h0000, TSQ_RESP_OKAY);
         wr(TSQ_OFF_QUEUE + 8'(4 * n), {8'(129 + 2 * n), 8'(128 + 2 * n)}, 2'b11, TSQ_RESP_OKAY);
         rd(TSQ_OFF_QUEUE + 8'(4 * n), {8'(129 + 2 * n), 8'(128 + 2 * n)}, TSQ_RESP_OKAY);
      end
      for (int p = 0; p < 32; p++)
      begin
         wr(TSQ_OFF_POINTER, 16'(p), 2'b01, TSQ_RESP_OKAY);
         wait_valid();
         chk("step byte", {24'h0, 8'(128 + p)}, {24'h0, active_step_byte});
         chk("step fields", {24'h0, 8'(128 + p)}, {24'h0, step_cmd, step_option});
      end
      wr(TSQ_OFF_LITERAL, 16'hA5C3, 2'b11, TSQ_RESP_OKAY);
      wr(TSQ_OFF_LITERAL, 16'h1234, 2'b01, TSQ_RESP_OKAY);
      wr(TSQ_OFF_LITERAL, 16'h7800, 2'b10, TSQ_RESP_OKAY);
      rd(TSQ_OFF_LITERAL, 16'h7834, TSQ_RESP_OKAY);
      wr(TSQ_OFF_POINTER, 16'hFFFF, 2'b11, TSQ_RESP_OKAY);
      rd(TSQ_OFF_POINTER, 16'h001F, TSQ_RESP_OKAY);
      wr(TSQ_OFF_POINTER, 16'h0000, 2'b10, TSQ_RESP_OKAY);
      rd(TSQ_OFF_POINTER, 16'h001F, TSQ_RESP_OKAY);
      // unmapped places answer with a decode error
      rd(8'h0C, 16'h0000, TSQ_RESP_DECERR);
      wr(8'hFC, 16'h5555, 2'b11, TSQ_RESP_DECERR);
      rd(TSQ_OFF_STATUS, 16'h0000, TSQ_RESP_OKAY);
      // program: add, jump to 31, then a no-op at 31 that wraps
      wr(TSQ_OFF_QUEUE, 16'hBF15, 2'b11, TSQ_RESP_OKAY);
      wr(TSQ_OFF_QUEUE + 8'h3C, 16'h009E, 2'b11, TSQ_RESP_OKAY);
      wr(TSQ_OFF_POINTER, 16'h0000, 2'b11, TSQ_RESP_OKAY);
      @(posedge aclk);
      seq_busy <= 1'b1;
      wr(TSQ_OFF_LITERAL, 16'h1111, 2'b11, TSQ_RESP_OKAY);
      wr(TSQ_OFF_POINTER, 16'h0005, 2'b11, TSQ_RESP_OKAY);
      wr(TSQ_OFF_QUEUE, 16'h0000, 2'b11, TSQ_RESP_OKAY);
      rd(TSQ_OFF_LITERAL, 16'h7834, TSQ_RESP_OKAY);
      rd(TSQ_OFF_POINTER, 16'h0000, TSQ_RESP_OKAY);
      rd(TSQ_OFF_QUEUE, 16'hBF15, TSQ_RESP_OKAY);
      rd(TSQ_OFF_STATUS, 16'h0001, TSQ_RESP_OKAY);
      exec_step(5'd1);
      chk("literal", 32'h0000_7824, {16'h0, literal_value});
      exec_step(5'd31);
      exec_step(5'd0);
      @(posedge aclk);
      seq_busy <= 1'b0;
      rd(TSQ_OFF_LITERAL, 16'h7824, TSQ_RESP_OKAY);
      // a second reset in mid-run clears the bank again
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(TSQ_OFF_LITERAL, 16'h0000, TSQ_RESP_OKAY);
      rd(TSQ_OFF_QUEUE, 16'h0000, TSQ_RESP_OKAY);
      test_done();
   end
endmodule
`default_nettype wire
